// >>> rtl/slcr_regs.sv
`timescale 1ns/10ps
`include "slcr_consts.svh"
module slcr_regs
   import slcr_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_b,
   input  slcr_req_t  req,
   input  wire logic  rd,
   input  wire logic [7:0] rd_cmd,
   input  wire logic  ov_fault_pin,
   input  wire logic  sw_tick_pin,
   input  wire logic  fault_clear,
   input  wire logic  cmd_off,
   input  wire logic [6:0] start_mant,
   input  wire logic [15:0] nom_vout,
   input  wire logic [15:0] iout_raw,
   input  wire logic [15:0] oc_fault_raw,
   input  wire logic [15:0] oc_warn_raw,
   input  wire logic  clr_flags,
   output logic [15:0] rd_data_q,
   output logic       rd_valid_q,
   output logic       alert_b_q,
   output logic       comm_err_q,
   output logic       invalid_data_q,
   output logic       ov_summary_q,
   output logic       vout_word_q,
   output logic       ov_vout_q,
   output logic       run_q,
   output logic       softstart_q,
   output logic [15:0] iout_corr_q,
   output logic [15:0] oc_fault_corr_q,
   output logic [15:0] oc_warn_corr_q,
   output slcr_pct_t  ov_pct_q,
   output slcr_pct_t  uv_pct_q
);
   logic [6:0]  stop_q;     // Writable stop threshold mantissa bits.
   logic [6:0]  gain_q;     // Writable sense gain mantissa bits.
   logic        off_sign_q; // Offset sign bit.
   logic [5:0]  off_low_q;  // Offset low mantissa bits.
   logic [15:0] ov_lim_q;   // Raw overvoltage limit request.
   logic [15:0] uv_lim_q;   // Raw undervoltage limit request.
   slcr_rsp_t   rsp_q;      // Reaction code.
   logic [2:0]  retry_q;    // Retry setting.
   slcr_pct_t   ov_sel;     // Snapped overvoltage choice.
   slcr_pct_t   uv_sel;     // Snapped undervoltage choice.
   logic [15:0] stop_word;  // Full stop word as read back.
   logic [15:0] off_word;   // Full offset word as read back.
   logic [15:0] stop_round; // Rounded stop mantissa in quarter volts.
   logic        stop_bad;   // Stop write refused.
   logic        react_bad;  // Reaction write refused.
   logic        wr_err;     // Any write refused this cycle.
   logic [2:0]  ovf_sync_q; // Fault pin synchroniser.
   logic [2:0]  tick_sync_q; // Tick pin synchroniser.
   logic        ovf_q;      // Filtered fault level.
   logic        tick_lvl_q; // Filtered tick level.
   logic        tick_prev_q; // Tick level one cycle ago.
   logic        tick;       // One pulse per switching cycle.
   logic        ov_run_q;   // Delayed overvoltage level for edge detect.

   // Request is rounded to the nearest even quarter-volt count, which
   // is the half-volt grid; an odd count rounds upward.
   always_comb begin
      stop_round = (req.data[10:0] + 16'h0001) & 16'hFFFE;
      stop_bad   = (req.data[15:11] != `SLCR_STOP_EXP) ||
                   (req.data[10:0] < `SLCR_STOP_MIN) ||
                   (req.data[10:0] > `SLCR_STOP_MAX);
      // Stop must sit below the start threshold.
      if (!stop_bad && stop_round[6:0] >= start_mant)
         stop_bad = 1'b1;
      react_bad = (req.data[5:3] != 3'h0) &&
                  (req.data[5:3] != 3'h7);
      wr_err = 1'b0;
      if (req.wr && req.cmd == `SLCR_CMD_STOP) wr_err = stop_bad;
      else if (req.wr && req.cmd == `SLCR_CMD_OV_REACT) wr_err = react_bad;
   end

   // Fixed fields are rebuilt on read, so no write can change them.
   always_comb begin
      stop_word = {`SLCR_STOP_EXP, 4'h0, stop_q};
      off_word  = {`SLCR_OFFSET_EXP, off_sign_q, {4{off_sign_q}},
                   off_low_q};
   end

   // Stop threshold holds its old value on any refused write.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) stop_q <= `SLCR_STOP_RST;
      else if (req.wr && req.cmd == `SLCR_CMD_STOP && !stop_bad)
         stop_q <= stop_round[6:0];
   end

   // Gain keeps only its low seven mantissa bits.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) gain_q <= `SLCR_GAIN_RST;
      else if (req.wr && req.cmd == `SLCR_CMD_GAIN)
         gain_q <= req.data[6:0];
   end

   // Offset takes sign and low bits; the rest alias away unflagged.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         off_sign_q <= 1'b0;
         off_low_q  <= 6'h00;
      end else if (req.wr && req.cmd == `SLCR_CMD_OFFSET) begin
         off_sign_q <= req.data[10];
         off_low_q  <= req.data[5:0];
      end
   end

   // Limit requests are stored raw and snapped combinationally.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ov_lim_q <= `SLCR_OV_LIM_RST;
         uv_lim_q <= `SLCR_UV_LIM_RST;
      end else if (req.wr && req.cmd == `SLCR_CMD_OV_LIMIT) begin
         ov_lim_q <= req.data;
      end else if (req.wr && req.cmd == `SLCR_CMD_UV_LIMIT) begin
         uv_lim_q <= req.data;
      end
   end

   // Snapping is held in registers; reset picks 112 and 88 percent.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ov_pct_q <= SLCR_PCT_2;
         uv_pct_q <= SLCR_PCT_2;
      end else begin
         ov_pct_q <= ov_sel;
         uv_pct_q <= uv_sel;
      end
   end

   slcr_pct_snap u_ov_snap (
      .req   (ov_lim_q),
      .nom   (nom_vout),
      .is_ov (1'b1),
      .sel   (ov_sel)
   );

   slcr_pct_snap u_uv_snap (
      .req   (uv_lim_q),
      .nom   (nom_vout),
      .is_ov (1'b0),
      .sel   (uv_sel)
   );

   // Reaction byte: whole write dropped if the retry field is illegal.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_q   <= SLCR_RSP_RUN;
         retry_q <= 3'h0;
      end else if (req.wr && req.cmd == `SLCR_CMD_OV_REACT && !react_bad) begin
         rsp_q   <= slcr_rsp_t'(req.data[7:6]);
         retry_q <= req.data[5:3];
      end
   end

   // Offset is added to the current report and both overcurrent limits.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         iout_corr_q     <= 16'h0000;
         oc_fault_corr_q <= 16'h0000;
         oc_warn_corr_q  <= 16'h0000;
      end else begin
         iout_corr_q     <= iout_raw
                            + {{5{off_sign_q}}, off_word[10:0]};
         oc_fault_corr_q <= oc_fault_raw + {{5{off_sign_q}}, off_word[10:0]};
         oc_warn_corr_q  <= oc_warn_raw + {{5{off_sign_q}}, off_word[10:0]};
      end
   end

   // Pins pass three flops; a change counts when the last two agree.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovf_sync_q  <= 3'h0;
         tick_sync_q <= 3'h0;
         ovf_q       <= 1'b0;
         tick_lvl_q  <= 1'b0;
         tick_prev_q <= 1'b0;
      end else begin
         ovf_sync_q  <= {ovf_sync_q[1:0], ov_fault_pin};
         tick_sync_q <= {tick_sync_q[1:0], sw_tick_pin};
         if (ovf_sync_q[1] == ovf_sync_q[2]) ovf_q <= ovf_sync_q[2];
         if (tick_sync_q[1] == tick_sync_q[2]) tick_lvl_q <= tick_sync_q[2];
         tick_prev_q <= tick_lvl_q;
      end
   end
   assign tick = tick_lvl_q & ~tick_prev_q;

   slcr_react_fsm u_react (
      .clk         (clk),
      .rst_b       (rst_b),
      .ov_fault    (ovf_q),
      .sw_tick     (tick),
      .fault_clear (fault_clear),
      .cmd_off     (cmd_off),
      .rsp         (rsp_q),
      .retry_all   (retry_q == 3'h7),
      .run_q       (run_q),
      .softstart_q (softstart_q)
   );

   // Status flags are sticky; a new event wins over a clear.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         comm_err_q     <= 1'b0;
         invalid_data_q <= 1'b0;
         ov_summary_q   <= 1'b0;
         vout_word_q    <= 1'b0;
         ov_vout_q      <= 1'b0;
         ov_run_q       <= 1'b0;
      end else begin
         ov_run_q <= ovf_q;
         if (wr_err) begin
            comm_err_q     <= 1'b1;
            invalid_data_q <= 1'b1;
         end else if (clr_flags) begin
            comm_err_q     <= 1'b0;
            invalid_data_q <= 1'b0;
         end
         if (ovf_q && !ov_run_q) begin
            ov_summary_q <= 1'b1;
            vout_word_q  <= 1'b1;
            ov_vout_q    <= 1'b1;
         end else if (clr_flags) begin
            ov_summary_q <= 1'b0;
            vout_word_q  <= 1'b0;
            ov_vout_q    <= 1'b0;
         end
      end
   end

   // Alert follows any pending flag, active low.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) alert_b_q <= 1'b1;
      else alert_b_q <= !(wr_err || (ovf_q && !ov_run_q) ||
                          comm_err_q || ov_summary_q);
   end

   // Read mux; unknown commands answer zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q  <= 16'h0000;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd;
         if (!rd) rd_data_q <= rd_data_q;
         else if (rd_cmd == `SLCR_CMD_STOP) rd_data_q <= stop_word;
         else if (rd_cmd == `SLCR_CMD_GAIN)
            rd_data_q <= {`SLCR_GAIN_EXP, 4'h0, gain_q};
         else if (rd_cmd == `SLCR_CMD_OFFSET) rd_data_q <= off_word;
         else if (rd_cmd == `SLCR_CMD_OV_LIMIT) rd_data_q <= ov_lim_q;
         else if (rd_cmd == `SLCR_CMD_OV_REACT)
            rd_data_q <= {8'h00, rsp_q, retry_q, `SLCR_REACT_LOW};
         else if (rd_cmd == `SLCR_CMD_UV_LIMIT) rd_data_q <= uv_lim_q;
         else rd_data_q <= 16'h0000;
      end
   end
endmodule

// >>> shared/slcr_consts.svh
`ifndef SLCR_CONSTS_SVH
`define SLCR_CONSTS_SVH
// Command codes of the registers held here.
`define SLCR_CMD_STOP      8'h36
`define SLCR_CMD_GAIN      8'h38
`define SLCR_CMD_OFFSET    8'h39
`define SLCR_CMD_OV_LIMIT  8'h40
`define SLCR_CMD_OV_REACT  8'h41
`define SLCR_CMD_UV_LIMIT  8'h44
// Fixed upper bits of the linear-format words.
`define SLCR_STOP_EXP      5'h1E
`define SLCR_GAIN_EXP      5'h11
`define SLCR_OFFSET_EXP    5'h1C
// Reset values of the writable fields; last, the fixed low bits of the reaction word.
`define SLCR_STOP_RST      7'h0A
`define SLCR_GAIN_RST      7'h62
`define SLCR_START_RST     7'h0B
`define SLCR_REACT_LOW     3'h4
// Raw limit words at reset: 112 and 88 percent of a 1.2 V nominal.
`define SLCR_OV_LIM_RST    16'h0560
`define SLCR_UV_LIM_RST    16'h0439
// Stop threshold mantissa range in quarter volts (2.50 V to 17.50 V).
`define SLCR_STOP_MIN      16'h000A
`define SLCR_STOP_MAX      16'h0046
// Switching cycles tolerated under reaction code 01.
`define SLCR_DELAY_CYC     3'h4
`endif

// >>> shared/slcr_pkg.sv
package slcr_pkg;
   // Overvoltage reaction codes.
   typedef enum logic [1:0] {
      SLCR_RSP_RUN   = 2'h0,
      SLCR_RSP_DELAY = 2'h1,
      SLCR_RSP_STOP  = 2'h2,
      SLCR_RSP_RETRY = 2'h3
   } slcr_rsp_t;
   // Selectable trip percentages, index 0 is the tightest.
   typedef enum logic [1:0] {
      SLCR_PCT_0 = 2'h0,
      SLCR_PCT_1 = 2'h1,
      SLCR_PCT_2 = 2'h2,
      SLCR_PCT_3 = 2'h3
   } slcr_pct_t;
   // Host write request carried as one bundle.
   typedef struct packed {
      logic        wr;
      logic [7:0]  cmd;
      logic [15:0] data;
   } slcr_req_t;
   // Fault-response controller states, one-hot.
   typedef enum logic [3:0] {
      SLCR_S_RUN   = 4'h1,
      SLCR_S_WAIT  = 4'h2,
      SLCR_S_OFF   = 4'h4,
      SLCR_S_SOFT  = 4'h8
   } slcr_state_t;
endpackage

// >>> rtl/slcr_pct_snap.sv
`timescale 1ns/10ps
`include "slcr_consts.svh"
// Snaps a requested trip voltage to the nearest of four percentages.
module slcr_pct_snap
   import slcr_pkg::*;
(
   input  wire logic [15:0] req,
   input  wire logic [15:0] nom,
   input  wire logic        is_ov,
   output slcr_pct_t        sel
);
   logic [31:0] p100;   // Request times one hundred.
   logic [31:0] mid_a;  // Boundary between the first two choices.
   logic [31:0] mid_b;  // Boundary between the middle two choices.
   logic [31:0] mid_c;  // Boundary between the last two choices.
   // Midpoints are scaled by 100 so only integer compares are needed.
   always_comb begin
      p100 = {16'h0000, req} * 32'd100;
      if (is_ov) begin
         mid_a = {16'h0000, nom} * 32'd109;
         mid_b = {16'h0000, nom} * 32'd111;
         mid_c = ({16'h0000, nom} * 32'd227) >> 1;
      end else begin
         mid_a = {16'h0000, nom} * 32'd91;
         mid_b = {16'h0000, nom} * 32'd89;
         mid_c = ({16'h0000, nom} * 32'd173) >> 1;
      end
   end
   // Out-of-range requests fall silently onto the end values.
   always_comb begin
      if (req[15]) begin
         sel = is_ov ? SLCR_PCT_0 : SLCR_PCT_3;
      end else if (is_ov) begin
         if (p100 < mid_a) sel = SLCR_PCT_0;
         else if (p100 < mid_b) sel = SLCR_PCT_1;
         else if (p100 < mid_c) sel = SLCR_PCT_2;
         else sel = SLCR_PCT_3;
      end else begin
         if (p100 >= mid_a) sel = SLCR_PCT_0;
         else if (p100 >= mid_b) sel = SLCR_PCT_1;
         else if (p100 >= mid_c) sel = SLCR_PCT_2;
         else sel = SLCR_PCT_3;
      end
   end
endmodule

// >>> rtl/slcr_react_fsm.sv
`timescale 1ns/10ps
`include "slcr_consts.svh"
// Overvoltage fault reaction controller, paced by switching-cycle ticks.
module slcr_react_fsm
   import slcr_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_b,
   input  wire logic  ov_fault,
   input  wire logic  sw_tick,
   input  wire logic  fault_clear,
   input  wire logic  cmd_off,
   input  slcr_rsp_t  rsp,
   input  wire logic  retry_all,
   output logic       run_q,
   output logic       softstart_q
);
   slcr_state_t st_q;   // Current state.
   logic [2:0]  cnt_q;  // Switching cycles seen under a pending fault.
   // Reaction code selects run-through, delayed stop or immediate stop.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q  <= SLCR_S_RUN;
         cnt_q <= 3'h0;
      end else begin
         case (st_q)
            SLCR_S_RUN: begin
               cnt_q <= 3'h0;
               if (ov_fault) begin
                  case (rsp)
                     SLCR_RSP_RUN:   st_q <= SLCR_S_RUN;
                     SLCR_RSP_DELAY: st_q <= SLCR_S_WAIT;
                     default:        st_q <= SLCR_S_OFF;
                  endcase
               end
            end
            SLCR_S_WAIT: begin
               // Keep switching four cycles before deciding.
               if (!ov_fault) st_q <= SLCR_S_RUN;
               else if (sw_tick) begin
                  cnt_q <= cnt_q + 3'h1;
                  if (cnt_q + 3'h1 >= `SLCR_DELAY_CYC)
                     st_q <= SLCR_S_OFF;
               end
            end
            SLCR_S_OFF: begin
               // Retry code 11 restarts unless cmd_off is set; else the retry field rules.
               if (cmd_off) st_q <= SLCR_S_OFF;
               else if (rsp == SLCR_RSP_RETRY || retry_all)
                  st_q <= SLCR_S_SOFT;
               else if (fault_clear) st_q <= SLCR_S_SOFT;
            end
            SLCR_S_SOFT: begin
               // Soft-start lasts one switching cycle in this model.
               if (ov_fault || cmd_off) st_q <= SLCR_S_OFF;
               else if (sw_tick) st_q <= SLCR_S_RUN;
            end
            default: st_q <= SLCR_S_RUN;
         endcase
      end
   end
   // Outputs are registered views of the current state, one cycle behind it.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q       <= 1'b1;
         softstart_q <= 1'b0;
      end else begin
         run_q       <= (st_q == SLCR_S_RUN) || (st_q == SLCR_S_WAIT);
         softstart_q <= (st_q == SLCR_S_SOFT);
      end
   end
endmodule

// >>> tb/slcr_properties.sv
`timescale 1ns/10ps
`include "slcr_consts.svh"
// Port checks on refusals, fixed read bits and fault flags.
module slcr_properties
   import slcr_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input slcr_req_t        req,
   input wire logic        rd,
   input wire logic [7:0]  rd_cmd,
   input wire logic        ov_fault_pin,
   input wire logic        clr_flags,
   input wire logic [15:0] rd_data_q,
   input wire logic        rd_valid_q,
   input wire logic        alert_b_q,
   input wire logic        comm_err_q,
   input wire logic        invalid_data_q,
   input wire logic        ov_summary_q,
   input wire logic        vout_word_q,
   input wire logic        ov_vout_q
);
   // Stop write with the legal exponent, so only the range and the start check decide.
   wire stop_wr = req.wr && req.cmd == `SLCR_CMD_STOP
                  && req.data[15:11] == `SLCR_STOP_EXP;
   // Reaction write whose retry field is neither all zeros nor all ones.
   wire bad_rs = req.wr && req.cmd == `SLCR_CMD_OV_REACT
                 && req.data[5:3] != 3'h0 && req.data[5:3] != 3'h7;
   // Limit writes clamp silently and must never raise an error.
   wire lim_wr = req.wr && (req.cmd == `SLCR_CMD_OV_LIMIT
                 || req.cmd == `SLCR_CMD_UV_LIMIT);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_stop_low_refused:
      assert property (stop_wr && req.data[10:0] < 11'h00A
         |=> comm_err_q && invalid_data_q) else $error("low stop taken");
   a_stop_high_refused:
      assert property (stop_wr && req.data[10:0] > 11'h046
         |=> comm_err_q && invalid_data_q) else $error("high stop taken");
   a_stop_fixed_bits:
      assert property (rd && rd_cmd == `SLCR_CMD_STOP |-> ##[1:2] (rd_valid_q
         && rd_data_q[15:7] == 9'h1E0)) else $error("stop fixed bits");
   a_gain_fixed_bits:
      assert property (rd && rd_cmd == `SLCR_CMD_GAIN |-> ##[1:2] (rd_valid_q
         && rd_data_q[15:7] == 9'h110)) else $error("gain fixed bits");
   a_offset_sign_copy:
      assert property (rd && rd_cmd == `SLCR_CMD_OFFSET |-> ##[1:2]
         (rd_valid_q && rd_data_q[15:11] == 5'h1C
         && rd_data_q[9:6] == {4{rd_data_q[10]}})) else $error("offset copy");
   a_react_low_bits:
      assert property (rd && rd_cmd == `SLCR_CMD_OV_REACT |-> ##[1:2]
         (rd_valid_q && rd_data_q[2:0] == 3'h4 && rd_data_q[15:8] == 8'h00))
         else $error("reaction fixed bits");
   a_retry_refused:
      assert property (bad_rs |=> (comm_err_q && invalid_data_q) ##[0:2]
         !alert_b_q) else $error("bad retry not flagged");
   a_limit_silent:
      assert property (lim_wr && !comm_err_q && !invalid_data_q
         |=> !comm_err_q && !invalid_data_q) else $error("limit flagged");
   a_ov_flags_set:
      assert property (ov_fault_pin [*8] |-> (ov_summary_q && vout_word_q
         && ov_vout_q) ##[0:2] !alert_b_q) else $error("fault flags missing");
   a_error_sticky:
      assert property (comm_err_q && !clr_flags |=> comm_err_q)
         else $error("error flag lost");
   a_alert_cause:
      assert property ($fell(alert_b_q) |-> comm_err_q || ov_summary_q)
         else $error("alert without cause");
endmodule

bind slcr_regs slcr_properties u_props (
   .clk(clk), .rst_b(rst_b), .req(req), .rd(rd), .rd_cmd(rd_cmd),
   .ov_fault_pin(ov_fault_pin), .clr_flags(clr_flags),
   .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .alert_b_q(alert_b_q),
   .comm_err_q(comm_err_q), .invalid_data_q(invalid_data_q),
   .ov_summary_q(ov_summary_q), .vout_word_q(vout_word_q),
   .ov_vout_q(ov_vout_q)
);

// >>> tb/slcr_host.sv
`timescale 1ns/10ps
// Host model: one write or read at a time, launched on falling edges.
module slcr_host
   import slcr_pkg::*;
(
   input  wire logic        clk,
   output slcr_req_t        req,
   output logic             rd,
   output logic [7:0]       rd_cmd,
   input  wire logic [15:0] rd_data_q,
   input  wire logic        rd_valid_q
);
   // Idle bus at time zero.
   initial begin
      req = '0;
      rd = 1'b0;
      rd_cmd = 8'h00;
   end
   // Write held over one rising edge, then released with inverted lines
   // so that a stale command or data word can never pass for a new one.
   task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
      @(negedge clk);
      req <= {1'b1, cmd, data};
      @(negedge clk);
      req <= {1'b0, ~cmd, ~data};
   endtask
   // Read pulse, then a bounded wait for the valid strobe.
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
                            output logic ok);
      int k;
      @(negedge clk);
      rd <= 1'b1;
      rd_cmd <= cmd;
      @(negedge clk);
      rd <= 1'b0;
      rd_cmd <= ~cmd;
      ok = 1'b0;
      data = 16'h0000;
      for (k = 0; k < 4 && !ok; k++) begin
         if (rd_valid_q === 1'b1) begin
            ok = 1'b1;
            data = rd_data_q;
         end else begin
            @(negedge clk);
         end
      end
   endtask
endmodule

// >>> tb/slcr_regs_bench.sv
`timescale 1ns/10ps
`include "slcr_consts.svh"
// Self-checking bench: host calls against expected register contents.
module slcr_regs_bench
   import slcr_pkg::*;
   ;
   logic        clk, rst_b, rd, rd_valid_q, alert_b_q, comm_err_q;
   logic        ov_fault_pin, sw_tick_pin, fault_clear, cmd_off, clr_flags;
   logic        invalid_data_q, ov_summary_q, vout_word_q, ov_vout_q;
   logic        run_q, softstart_q;
   logic [7:0]  rd_cmd;
   logic [6:0]  start_mant;
   logic [15:0] nom_vout, iout_raw, oc_fault_raw, oc_warn_raw, rd_data_q;
   logic [15:0] iout_corr_q, oc_fault_corr_q, oc_warn_corr_q;
   slcr_req_t   req;
   slcr_pct_t   ov_pct_q, uv_pct_q;
   int          mismatches = 0;
   int          n_tests = 0;
   int          i, ss_n = 0;
   // Reset contents of every register, looked at after an unmapped write.
   logic [7:0]  rst_cmd [6] = '{8'h36, 8'h38, 8'h39, 8'h40, 8'h41, 8'h44};
   logic [15:0] rst_val [6] = '{16'hF00A, 16'h8862, 16'hE000, 16'h0560,
                                16'h0004, 16'h0439};
   // Limit requests against a nominal of 0x04CD and the index expected.
   logic [7:0]  l_cmd [7] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h44, 8'h44, 8'h44};
   logic [15:0] l_dat [7] = '{16'h0400, 16'h0548, 16'h7FFF, 16'h8000,
                              16'h0452, 16'h7FFF, 16'h0000};
   logic [1:0]  l_pct [7] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h0, 2'h3};
   // Reaction codes tried under a live fault.
   logic [7:0]  codes [5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hB8};

   slcr_regs u_dut (.clk(clk), .rst_b(rst_b), .req(req), .rd(rd),
      .rd_cmd(rd_cmd), .ov_fault_pin(ov_fault_pin), .sw_tick_pin(sw_tick_pin),
      .fault_clear(fault_clear), .cmd_off(cmd_off), .start_mant(start_mant),
      .nom_vout(nom_vout), .iout_raw(iout_raw), .oc_fault_raw(oc_fault_raw),
      .oc_warn_raw(oc_warn_raw), .clr_flags(clr_flags), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .alert_b_q(alert_b_q), .comm_err_q(comm_err_q),
      .invalid_data_q(invalid_data_q), .ov_summary_q(ov_summary_q),
      .vout_word_q(vout_word_q), .ov_vout_q(ov_vout_q), .run_q(run_q),
      .softstart_q(softstart_q), .iout_corr_q(iout_corr_q),
      .oc_fault_corr_q(oc_fault_corr_q), .oc_warn_corr_q(oc_warn_corr_q),
      .ov_pct_q(ov_pct_q), .uv_pct_q(uv_pct_q));
   slcr_host u_host (.clk(clk), .req(req), .rd(rd), .rd_cmd(rd_cmd),
      .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

   // 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Soft-start cycles are counted, as the pulses may be shorter than a check.
   always @(posedge clk) begin
      if (softstart_q === 1'b1) ss_n++;
   end
   // Watchdog so a hang ends in the normal report.
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      stop_test();
   end
   task automatic stop_test();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Read through the host; a missing answer ends the run.
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
      logic [15:0] d;
      logic        ok;
      u_host.read_word(c, d, ok);
      if (!ok) begin
         mismatches++;
         stop_test();
      end
      chk($sformatf("reg %h", c), e, d);
   endtask
   task automatic clr();
      @(negedge clk);
      clr_flags <= 1'b1;
      @(negedge clk);
      clr_flags <= 1'b0;
   endtask
   task automatic flags(input logic e);
      chk("comm err", {15'h0, e}, {15'h0, comm_err_q});
      chk("invalid", {15'h0, e}, {15'h0, invalid_data_q});
      if (e) chk("alert", 16'h0, {15'h0, alert_b_q});
   endtask
   // Switching ticks, three cycles high and three low.
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge clk);
         sw_tick_pin <= 1'b1;
         repeat (3) @(negedge clk);
         sw_tick_pin <= 1'b0;
         repeat (2) @(negedge clk);
      end
   endtask
   task automatic stop_try(input logic [6:0] st, input logic [15:0] d,
                           input logic [15:0] e, input logic bad);
      @(negedge clk);
      start_mant <= st;
      clr();
      u_host.write_word(`SLCR_CMD_STOP, d);
      rd_chk(`SLCR_CMD_STOP, e);
      flags(bad);
   endtask
   // Fault held over six ticks, removed, then recovery checked.
   task automatic fault_run(input logic [7:0] c);
      logic rs;
      int   base;
      rs = c[7:6] == 2'h3 || (c[5:3] == 3'h7 && c[7:6] != 2'h0);
      u_host.write_word(`SLCR_CMD_OV_REACT, c);
      clr();
      base = ss_n;
      ov_fault_pin <= 1'b1;
      tick(2);
      chk("ov flags", 16'h7, {13'h0, ov_summary_q, vout_word_q, ov_vout_q});
      chk("ov alert", 16'h0, {15'h0, alert_b_q});
      if (c[7:6] != 2'h3)
         chk("run early", {15'h0, c[7:6] <= 2'h1}, {15'h0, run_q});
      tick(4);
      if (!rs) chk("run late", {15'h0, c[7:6] == 2'h0}, {15'h0, run_q});
      ov_fault_pin <= 1'b0;
      tick(3);
      if (c[7:6] != 2'h0 && !rs) begin
         chk("latched", 16'h0, {15'h0, run_q});
         fault_clear <= 1'b1;
         @(negedge clk);
         fault_clear <= 1'b0;
         tick(3);
      end
      chk("run after", 16'h1, {15'h0, run_q});
      if (rs) chk("restart", 16'h1, {15'h0, ss_n > base});
   endtask

   initial begin
      rst_b = 1'b0;
      ov_fault_pin = 1'b0;
      sw_tick_pin = 1'b0;
      fault_clear = 1'b0;
      cmd_off = 1'b0;
      clr_flags = 1'b0;
      start_mant = 7'h50;
      nom_vout = 16'h04CD;
      iout_raw = 16'h0123;
      oc_fault_raw = 16'h0014;
      oc_warn_raw = 16'h000F;
      repeat (16) @(negedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("run", 16'h1, {15'h0, run_q});
      chk("alert", 16'h1, {15'h0, alert_b_q});
      chk("ov pct", 16'h2, {14'h0, ov_pct_q});
      chk("uv pct", 16'h2, {14'h0, uv_pct_q});
      // An unmapped write must leave every register at its reset value.
      u_host.write_word(8'h37, 16'hFFFF);
      for (i = 0; i < 6; i++) begin
         rd_chk(rst_cmd[i], rst_val[i]);
      end
      chk("iout", iout_raw, iout_corr_q);
      chk("oc fault", oc_fault_raw, oc_fault_corr_q);
      chk("oc warn", oc_warn_raw, oc_warn_corr_q);
      stop_try(7'h50, 16'hF00B, 16'hF00C, 1'b0);
      stop_try(7'h50, 16'hF046, 16'hF046, 1'b0);
      stop_try(7'h50, 16'hF047, 16'hF046, 1'b1);
      stop_try(7'h50, 16'hF009, 16'hF046, 1'b1);
      stop_try(7'h50, 16'h7814, 16'hF046, 1'b1);
      stop_try(7'h20, 16'hF01F, 16'hF046, 1'b1);
      stop_try(7'h20, 16'hF01E, 16'hF01E, 1'b0);
      stop_try(7'h50, 16'hF00A, 16'hF00A, 1'b0);
      clr();
      u_host.write_word(`SLCR_CMD_GAIN, 16'hFFFF);
      rd_chk(`SLCR_CMD_GAIN, 16'h887F);
      u_host.write_word(`SLCR_CMD_OFFSET, 16'h0401);
      rd_chk(`SLCR_CMD_OFFSET, 16'hE7C1);
      chk("iout neg", 16'h00E4, iout_corr_q);
      chk("oc warn neg", 16'hFFD0, oc_warn_corr_q);
      u_host.write_word(`SLCR_CMD_OFFSET, 16'hFBFF);
      rd_chk(`SLCR_CMD_OFFSET, 16'hE03F);
      for (i = 0; i < 7; i++) begin
         u_host.write_word(l_cmd[i], l_dat[i]);
         repeat (3) @(negedge clk);
         chk("pct", {14'h0, l_pct[i]}, {14'h0, (l_cmd[i] == 8'h40) ?
             ov_pct_q : uv_pct_q});
      end
      flags(1'b0);
      u_host.write_word(`SLCR_CMD_OV_REACT, 16'h00F8);
      rd_chk(`SLCR_CMD_OV_REACT, 16'h00FC);
      u_host.write_word(`SLCR_CMD_OV_REACT, 16'h0068);
      rd_chk(`SLCR_CMD_OV_REACT, 16'h00FC);
      flags(1'b1);
      for (i = 0; i < 5; i++) begin
         fault_run(codes[i]);
      end
      stop_test();
   end
endmodule
